// *** etei_edge_det.sv ***
`timescale 1ns/10ps
// Synchroniser plus selectable edge detector for one pin
module etei_edge_det (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  input wire logic [1:0] sel_in,
  output logic edge_out
);
  logic sync1;
  logic sync2;
  logic prev;

  // Two flops, then a history flop for comparison
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      prev <= 1'b1;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  // Code 00 is reserved and detects nothing
  always_comb begin
    case (sel_in)
      2'h1: edge_out = sync2 & ~prev;
      2'h2: edge_out = ~sync2 & prev;
      2'h3: edge_out = sync2 ^ prev;
      default: edge_out = 1'b0;
    endcase
  end
endmodule

// *** etei_pin_src.sv ***
`timescale 1ns/10ps
// ****************
// External sources on the two interrupt pins
// ****************
module etei_pin_src (
  // Clock
  input wire logic clk_in,
  // Pins
  output logic pin_a_out,
  output logic pin_b_out
);
  // Idle high so a fresh reset sees no stray edge
  initial begin
    pin_a_out = 1'b1;
    pin_b_out = 1'b1;
  end
  task automatic set_pin(input logic sel_b, input logic lvl);
    @(posedge clk_in);
    if (sel_b) begin
      pin_b_out <= lvl;
    end else begin
      pin_a_out <= lvl;
    end
  endtask
endmodule

// *** etei_pkg.sv ***
package etei_pkg;
  // ****************
  // Register offsets
  // ****************
  localparam logic [7:0] TIMER_CTRL_REG_ADDR = 8'h88;
  localparam logic [7:0] EDGE_SELECT_REG_ADDR = 8'h8f;
  localparam logic [7:0] IRQ_ENABLE_REG_ADDR = 8'ha8;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'hc0;
  localparam logic [7:0] IRQ_CLEAR_ADDR = 8'hc1;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'hc2;
  // ****************
  // Field positions
  // ****************
  localparam int IRQ_A_SEL_LSB = 0;
  localparam int IRQ_B_SEL_LSB = 2;
  localparam int IRQ_A_FLAG_BIT = 1;
  localparam int IRQ_B_FLAG_BIT = 3;
  localparam int IRQ_A_EN_BIT = 0;
  localparam int IRQ_B_EN_BIT = 2;
  localparam int GLOBAL_EN_BIT = 7;
  // ****************
  // Reset values and codes
  // ****************
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [3:0] EDGE_SELECT_RESET = 4'ha;
  localparam logic [7:0] TIMER_CTRL_RESET = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam logic [15:0] IRQ_A_VECTOR = 16'h0003;
  localparam logic [15:0] IRQ_B_VECTOR = 16'h0013;
  // ****************
  // Service sequencer
  // ****************
  typedef enum logic [1:0] {
    ETEI_IDLE = 2'b00,
    ETEI_TAKE = 2'b01,
    ETEI_SERVE = 2'b10
  } etei_state_t;
endpackage

// *** etei_top.sv ***
`timescale 1ns/10ps
// What this block does
// - Bits 3:2 select the second source's edge: 01 rise, 10 fall, 11 both.
// - Bits 1:0 select the first source's edge the same way, 00 reserved.
// - Both edge fields reset to 10, falling edge.
// - With source and global enable set, a selected edge sets the flag.
// - The first source vectors to 0x0003, the second to 0x0013.
// - Hardware clears a taken source's flag before its routine runs.
// - Bit 7 of the enable register is the global enable, reset zero.
// - Bit 2 of the enable register enables the second source, reset zero.
// - Bit 0 of the enable register enables the first source, reset zero.
// - Bit 3 of the control register is the second source's flag.
// - Bit 1 of the control register is the first source's flag.
// - Upper edge-select bits read zero and ignore writes.
module etei_top
  import etei_pkg::*;
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  // Register port
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  // Interrupt pins
  input wire logic EXT_IRQ_A_PIN_IN,
  input wire logic EXT_IRQ_B_PIN_IN,
  // Core handshake
  output logic CORE_IRQ_REQ_OUT,
  output logic [15:0] CORE_VECTOR_OUT,
  input wire logic CORE_IRQ_ACK_IN,
  output logic CORE_SERVE_START_OUT,
  // Event interrupt
  output logic IRQ_OUT
);
  import etei_pkg::*;

  // ****************
  // State
  // ****************
  logic [3:0] edge_select_reg;
  logic [7:0] timer_ctrl_reg;
  logic [7:0] irq_enable_reg;
  logic [1:0] evt_status;
  logic [1:0] evt_mask;
  logic edge_a;
  logic edge_b;
  logic set_a;
  logic set_b;
  logic take_a;
  logic take_b;
  logic taken_is_b;
  logic clr_wr;
  etei_state_t state;
  etei_state_t next_state;
  logic wr_ctrl;
  logic wr_en;
  logic wr_sel;

  assign wr_ctrl = REG_WR_IN && REG_ADDR_IN == TIMER_CTRL_REG_ADDR;
  assign wr_en = REG_WR_IN && REG_ADDR_IN == IRQ_ENABLE_REG_ADDR;
  assign wr_sel = REG_WR_IN && REG_ADDR_IN == EDGE_SELECT_REG_ADDR;
  assign clr_wr = REG_WR_IN && REG_ADDR_IN == IRQ_CLEAR_ADDR;

  // ****************
  // Edge detectors
  // ****************
  etei_edge_det u_det_a (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .pin_in(EXT_IRQ_A_PIN_IN),
    .sel_in(edge_select_reg[IRQ_A_SEL_LSB +: 2]),
    .edge_out(edge_a)
  );
  etei_edge_det u_det_b (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .pin_in(EXT_IRQ_B_PIN_IN),
    .sel_in(edge_select_reg[IRQ_B_SEL_LSB +: 2]),
    .edge_out(edge_b)
  );

  assign set_a = edge_a && irq_enable_reg[IRQ_A_EN_BIT]
    && irq_enable_reg[GLOBAL_EN_BIT];
  assign set_b = edge_b && irq_enable_reg[IRQ_B_EN_BIT]
    && irq_enable_reg[GLOBAL_EN_BIT];

  // ****************
  // Configuration registers
  // ****************
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      edge_select_reg <= EDGE_SELECT_RESET;
    end else if (wr_sel) begin
      edge_select_reg <= REG_WDATA_IN[3:0];
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      irq_enable_reg <= IRQ_ENABLE_RESET;
    end else if (wr_en) begin
      irq_enable_reg <= REG_WDATA_IN;
    end
  end

  // ****************
  // Request flags
  // ****************
  // Set wins over a software write or hardware clear in the same cycle
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      timer_ctrl_reg <= TIMER_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        timer_ctrl_reg <= REG_WDATA_IN & 8'hfa;
      end
      if (take_a) begin
        timer_ctrl_reg[IRQ_A_FLAG_BIT] <= 1'b0;
      end
      if (take_b) begin
        timer_ctrl_reg[IRQ_B_FLAG_BIT] <= 1'b0;
      end
      if (set_a) begin
        timer_ctrl_reg[IRQ_A_FLAG_BIT] <= 1'b1;
      end
      if (set_b) begin
        timer_ctrl_reg[IRQ_B_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // ****************
  // Service sequencer
  // ****************
  // Source A has priority, as it has the lower vector
  assign take_a = state == ETEI_IDLE && CORE_IRQ_ACK_IN
    && timer_ctrl_reg[IRQ_A_FLAG_BIT];
  assign take_b = state == ETEI_IDLE && CORE_IRQ_ACK_IN
    && !timer_ctrl_reg[IRQ_A_FLAG_BIT] && timer_ctrl_reg[IRQ_B_FLAG_BIT];

  always_comb begin
    next_state = state;
    case (state)
      ETEI_IDLE: begin
        if (take_a || take_b) begin
          next_state = ETEI_TAKE;
        end
      end
      ETEI_TAKE: next_state = ETEI_SERVE;
      ETEI_SERVE: next_state = ETEI_IDLE;
      default: next_state = ETEI_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      state <= ETEI_IDLE;
      taken_is_b <= 1'b0;
    end else begin
      state <= next_state;
      if (take_a || take_b) begin
        taken_is_b <= take_b;
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      CORE_IRQ_REQ_OUT <= 1'b0;
      CORE_VECTOR_OUT <= IRQ_A_VECTOR;
      CORE_SERVE_START_OUT <= 1'b0;
    end else begin
      CORE_IRQ_REQ_OUT <= irq_enable_reg[GLOBAL_EN_BIT]
        && (next_state == ETEI_IDLE)
        && (timer_ctrl_reg[IRQ_A_FLAG_BIT] || timer_ctrl_reg[IRQ_B_FLAG_BIT]
          || set_a || set_b) && !(take_a || take_b);
      if (take_a || take_b) begin
        CORE_VECTOR_OUT <= take_b ? IRQ_B_VECTOR : IRQ_A_VECTOR;
      end
      CORE_SERVE_START_OUT <= state == ETEI_TAKE;
    end
  end

  // ****************
  // Event status and interrupt line
  // ****************
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      evt_status <= 2'h0;
      evt_mask <= 2'h0;
    end else begin
      if (REG_WR_IN && REG_ADDR_IN == IRQ_MASK_ADDR) begin
        evt_mask <= REG_WDATA_IN[1:0];
      end
      evt_status <= (evt_status & ~({2{clr_wr}} & REG_WDATA_IN[1:0]))
        | {edge_b, edge_a};
    end
  end

  assign IRQ_OUT = |(evt_status & evt_mask);

  // ****************
  // Read port
  // ****************
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      REG_RDATA_OUT <= 8'h00;
    end else if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        TIMER_CTRL_REG_ADDR: REG_RDATA_OUT <= timer_ctrl_reg;
        EDGE_SELECT_REG_ADDR: REG_RDATA_OUT <= {4'h0, edge_select_reg};
        IRQ_ENABLE_REG_ADDR: REG_RDATA_OUT <= irq_enable_reg;
        IRQ_STATUS_ADDR: REG_RDATA_OUT <= {6'h00, evt_status};
        IRQ_MASK_ADDR: REG_RDATA_OUT <= {6'h00, evt_mask};
        default: REG_RDATA_OUT <= 8'h00;
      endcase
    end else begin
      REG_RDATA_OUT <= 8'h00;
    end
  end

  // ****************
  // Checks
  // ****************
  sequence s_take_a;
    take_a;
  endsequence
  sequence s_take_b;
    take_b;
  endsequence
  sequence s_serve;
    ##1 state == ETEI_TAKE ##1 CORE_SERVE_START_OUT;
  endsequence
  sequence s_fall_b;
    edge_select_reg[3:2] == 2'h2 && $fell(EXT_IRQ_B_PIN_IN)
      ##1 !EXT_IRQ_B_PIN_IN
      ##1 !EXT_IRQ_B_PIN_IN && edge_select_reg[3:2] == 2'h2;
  endsequence

  AST_VEC_A: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    s_take_a |=> CORE_VECTOR_OUT == 16'h0003)
    else $error("vector for source a wrong");

  AST_VEC_B: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    take_b |=> CORE_VECTOR_OUT == 16'h0013)
    else $error("vector for source b wrong");

  AST_VEC_SRC: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    state == ETEI_TAKE
      |-> CORE_VECTOR_OUT == (taken_is_b ? 16'h0013 : 16'h0003))
    else $error("vector does not match the taken source");

  AST_CLR_A: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    s_take_a and !set_a |-> s_serve and ##1 !timer_ctrl_reg[1])
    else $error("flag a not cleared before service");

  AST_CLR_B: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    s_take_b and !set_b |-> s_serve and ##1 !timer_ctrl_reg[3])
    else $error("flag b not cleared before service");

  AST_REQ_OFF: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    take_a || take_b |=> !CORE_IRQ_REQ_OUT)
    else $error("request still raised after take");

  AST_SET_A: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    set_a |=> timer_ctrl_reg[1])
    else $error("flag a not set on edge");

  AST_SET_B: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    set_b |=> timer_ctrl_reg[3])
    else $error("flag b not set on edge");

  AST_GLOBAL: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    !irq_enable_reg[GLOBAL_EN_BIT] && !wr_ctrl
      |=> !$rose(timer_ctrl_reg[IRQ_A_FLAG_BIT])
      && !$rose(timer_ctrl_reg[IRQ_B_FLAG_BIT]))
    else $error("flag set while globally disabled");

  AST_RSVD: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    REG_RD_IN && REG_ADDR_IN == 8'h8f |=> REG_RDATA_OUT[7:4] == 4'h0)
    else $error("reserved edge bits read nonzero");

  AST_FALL: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    $fell(SYS_RST_IN) |-> edge_select_reg == 4'ha)
    else $error("edge select not falling after reset");

  AST_NONE_A: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    edge_select_reg[1:0] == 2'h0 |-> !edge_a)
    else $error("reserved code found an edge on source a");

  AST_NONE_B: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    edge_select_reg[3:2] == 2'h0 |-> !edge_b)
    else $error("reserved code found an edge on source b");

  AST_FALL_B: assert property (
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    s_fall_b |-> edge_b)
    else $error("falling edge on source b missed");

  AST_SYNC: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    edge_select_reg[1:0] == 2'h1 && $rose(EXT_IRQ_A_PIN_IN)
      && irq_enable_reg[0] && irq_enable_reg[7] ##1 EXT_IRQ_A_PIN_IN
      ##1 EXT_IRQ_A_PIN_IN && edge_select_reg[1:0] == 2'h1
      && irq_enable_reg[0] && irq_enable_reg[7]
      |-> set_a)
    else $error("rising edge not seen after two syncs");
endmodule

// *** test_edge_triggered_ext_interrupts.sv ***
`timescale 1ns/10ps
module test_edge_triggered_ext_interrupts;
  import etei_pkg::*;
  logic clk, rst, wr, rd, ack, pin_a, pin_b, req, serve, irq, b;
  logic [7:0] addr, wdata, rdata;
  logic [15:0] vec;
  int num_errors = 0;
  int n_compared = 0;
  int k;
  // Source b, edge code, start level, end level, flag expected
  logic [5:0] rows [16] = '{6'b0_01_011, 6'b0_01_100, 6'b0_10_101,
    6'b0_10_010, 6'b0_11_011, 6'b0_11_101, 6'b0_00_010, 6'b0_00_100,
    6'b1_01_011, 6'b1_01_100, 6'b1_10_101, 6'b1_10_010, 6'b1_11_011,
    6'b1_11_101, 6'b1_00_010, 6'b1_00_100};
  etei_top u_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdata), .EXT_IRQ_A_PIN_IN(pin_a),
    .EXT_IRQ_B_PIN_IN(pin_b), .CORE_IRQ_REQ_OUT(req),
    .CORE_VECTOR_OUT(vec), .CORE_IRQ_ACK_IN(ack),
    .CORE_SERVE_START_OUT(serve), .IRQ_OUT(irq));
  etei_pin_src u_src (.clk_in(clk), .pin_a_out(pin_a), .pin_b_out(pin_b));
  // ****************
  // Bus and check tasks
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask
  task automatic take(input logic [15:0] exp);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    #1;
    chk(vec, exp);
    chk({15'h0, req}, 16'h0);
    k = 0;
    while (serve !== 1'b1 && k < 4) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk({15'h0, serve}, 16'h1);
  endtask
  task automatic wrap_up();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Hang guard
  initial begin
    #400000;
    num_errors++;
    wrap_up();
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    ack = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk(EDGE_SELECT_REG_ADDR, 8'h0a);
    rd_chk(IRQ_ENABLE_REG_ADDR, 8'h00);
    rd_chk(TIMER_CTRL_REG_ADDR, 8'h00);
    wr_reg(IRQ_ENABLE_REG_ADDR, 8'h85);
    rd_chk(IRQ_ENABLE_REG_ADDR, 8'h85);
    foreach (rows[i]) begin
      b = rows[i][5];
      wr_reg(EDGE_SELECT_REG_ADDR, {4'h0, rows[i][4:3], rows[i][4:3]});
      u_src.set_pin(b, rows[i][2]);
      repeat (5) @(posedge clk);
      wr_reg(TIMER_CTRL_REG_ADDR, 8'h00);
      wr_reg(IRQ_CLEAR_ADDR, 8'h03);
      u_src.set_pin(b, rows[i][1]);
      repeat (5) @(posedge clk);
      rd_chk(TIMER_CTRL_REG_ADDR, {4'h0, b & rows[i][0], 1'b0,
        ~b & rows[i][0], 1'b0});
    end
    wr_reg(EDGE_SELECT_REG_ADDR, 8'hff);
    rd_chk(EDGE_SELECT_REG_ADDR, 8'h0f);
    wr_reg(EDGE_SELECT_REG_ADDR, 8'h0a);
    wr_reg(IRQ_ENABLE_REG_ADDR, 8'h05);
    u_src.set_pin(1'b0, 1'b1);
    u_src.set_pin(1'b1, 1'b1);
    repeat (5) @(posedge clk);
    wr_reg(TIMER_CTRL_REG_ADDR, 8'h00);
    wr_reg(IRQ_CLEAR_ADDR, 8'h03);
    u_src.set_pin(1'b0, 1'b0);
    repeat (5) @(posedge clk);
    rd_chk(TIMER_CTRL_REG_ADDR, 8'h00);
    rd_chk(IRQ_STATUS_ADDR, 8'h01);
    chk({15'h0, irq}, 16'h0);
    wr_reg(IRQ_MASK_ADDR, 8'h01);
    #1;
    chk({15'h0, irq}, 16'h1);
    wr_reg(IRQ_CLEAR_ADDR, 8'h01);
    #1;
    chk({15'h0, irq}, 16'h0);
    wr_reg(IRQ_ENABLE_REG_ADDR, 8'h85);
    u_src.set_pin(1'b0, 1'b1);
    repeat (5) @(posedge clk);
    wr_reg(TIMER_CTRL_REG_ADDR, 8'h00);
    u_src.set_pin(1'b0, 1'b0);
    u_src.set_pin(1'b1, 1'b0);
    repeat (5) @(posedge clk);
    rd_chk(TIMER_CTRL_REG_ADDR, 8'h0a);
    chk({15'h0, req}, 16'h1);
    take(IRQ_A_VECTOR);
    rd_chk(TIMER_CTRL_REG_ADDR, 8'h08);
    take(IRQ_B_VECTOR);
    rd_chk(TIMER_CTRL_REG_ADDR, 8'h00);
    wr_reg(TIMER_CTRL_REG_ADDR, 8'h02);
    take(IRQ_A_VECTOR);
    rd_chk(TIMER_CTRL_REG_ADDR, 8'h00);
    wr_reg(EDGE_SELECT_REG_ADDR, 8'h05);
    rd_chk(EDGE_SELECT_REG_ADDR, 8'h05);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(EDGE_SELECT_REG_ADDR, 8'h0a);
    rd_chk(IRQ_ENABLE_REG_ADDR, 8'h00);
    rd_chk(TIMER_CTRL_REG_ADDR, 8'h00);
    wrap_up();
  end
endmodule
